/* File: hdl/ldo_state_control_regs.sv */
// State control registers for three low-dropout rails, with standby-exit copy.
// Assumes the serial port engine presents decoded register accesses on sys_clk,
// and that the standby-exit pin and monitor inputs are synchronous to sys_clk.
//
// What this block does
// - State field bits 2:0: 4 off, 5 low power, 6/7 active, 0-3 reserved.
// - Exit field bits 5:3: codes 4-7 copied into state on standby exit.
// - Exit codes 0-3 leave the rail state untouched on standby exit.
// - Radio rail register at 0x4C, read/write, resets to 0x24.
// - Processor always-on rail register at 0x3D, read/write, resets to 0x07.
// - Memory rail register at 0x3E, read/write, resets to 0x3C.
// - Bits 7:6 of each rail register are reserved with no function.
// - Writing one rail register never alters another rail.
// - A rail that is shut down has its output discharge enabled.
// - Over-current and under-voltage of each rail are reported as faults.
`timescale 1ns/1ps
`default_nettype none
`include "ldo_rail_defines.svh"

module ldo_state_control_regs (
    input  wire logic                    sys_clk,      // 10 MHz register clock
    input  wire logic                    rst,          // Synchronous reset, high
    input  wire logic [7:0]              regAddr,      // Register address
    input  wire logic                    regWrite,     // Write strobe, one cycle
    input  wire logic [7:0]              regWrData,    // Write data
    input  wire logic                    regRead,      // Read strobe, one cycle
    output logic [7:0]                   regRdData,    // Read data, next cycle
    input  wire logic                    standbyExit,  // Standby-exit pin
    input  wire ldo_rail_pkg::rail_sense_t [2:0] railSense, // Monitor comparators
    output ldo_rail_pkg::rail_drive_t  [2:0] railDrive,  // Regulator controls
    output ldo_rail_pkg::rail_sense_t  [2:0] railFault   // Fault indications
);
    import ldo_rail_pkg::*;

    // -----------------------------------------------------------------
    // Per-rail constants, packed so a generate index can slice them
    // -----------------------------------------------------------------
    localparam logic [23:0] RAIL_ADDRS  = {`MEM_RAIL_ADDR, `PROC_AON_RAIL_ADDR,
                                           `RADIO_RAIL_ADDR};
    localparam logic [23:0] RAIL_RESETS = {`MEM_RAIL_RESET, `PROC_AON_RAIL_RESET,
                                           `RADIO_RAIL_RESET};

    // Map a state code onto the regulator controls
    function automatic rail_drive_t driveOf(input logic [2:0] code);
        rail_drive_t d;
        d.enable    = (code == `CODE_LOW_POWER) || (code == `CODE_ACTIVE_A) ||
                      (code == `CODE_ACTIVE_B);
        d.lowPower  = (code == `CODE_LOW_POWER);
        d.discharge = !d.enable;
        return d;
    endfunction : driveOf

    rail_ctrl_t [2:0] ctrl;
    rail_ctrl_t [2:0] nextCtrl;
    logic       [2:0] hit;
    logic       [2:0] wrHit;
    logic       [2:0] doCopy;
    logic             exitPrev;
    logic             exitEdge;
    logic       [7:0] readMux;

    // -----------------------------------------------------------------
    // Standby-exit edge detect
    // -----------------------------------------------------------------
    // Prev resets high so a pin already high at reset release makes no copy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            exitPrev <= `EXIT_PIN_RESET;
        end else begin
            exitPrev <= standbyExit;
        end
    end

    // One pulse per rising edge, shared by every rail
    assign exitEdge = standbyExit && !exitPrev;

    // -----------------------------------------------------------------
    // Rail registers
    // -----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `RAIL_COUNT; i = i + 1) begin : g_rail
            // Each rail decodes only its own address
            assign hit[i]    = (regAddr == RAIL_ADDRS[8*i +: 8]);
            assign wrHit[i]  = regWrite && hit[i];
            assign doCopy[i] = exitEdge && ctrl[i].exitState[`CODE_VALID_BIT];

            // Reserved bits 7:6 of the write data are simply dropped
            assign nextCtrl[i].exitState = wrHit[i] ? regWrData[`EXIT_MSB:`EXIT_LSB]
                                                    : ctrl[i].exitState;
            // Copy beats a same-cycle write so the exit event is never lost
            assign nextCtrl[i].state = doCopy[i] ? ctrl[i].exitState
                                     : wrHit[i]  ? regWrData[`STATE_MSB:`STATE_LSB]
                                     : ctrl[i].state;

            // Register and its decoded drive move together
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    ctrl[i]      <= RAIL_RESETS[8*i +: 6];
                    railDrive[i] <= driveOf(RAIL_RESETS[8*i +: 3]);
                end else begin
                    ctrl[i]      <= nextCtrl[i];
                    railDrive[i] <= driveOf(nextCtrl[i].state);
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    // Unmapped addresses read as zero; reserved bits always zero
    assign readMux = hit[0] ? {2'b00, ctrl[0]}
                   : hit[1] ? {2'b00, ctrl[1]}
                   : hit[2] ? {2'b00, ctrl[2]}
                   : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= readMux;
        end
    end

    // -----------------------------------------------------------------
    // Fault reporting
    // -----------------------------------------------------------------
    // Registered copy of the comparators; no filtering, so glitches show
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            railFault <= '0;
        end else begin
            railFault <= railSense;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Reset state of registers and drives; reset must not mask these two
    reset_values_a: assert property (disable iff (1'b0) rst |=>
        ctrl[0] == 6'h24 && ctrl[1] == 6'h07 && ctrl[2] == 6'h3C)
        else $error("Rail registers not at reset values");

    drive_reset_a: assert property (disable iff (1'b0) rst |=>
        railDrive == 9'b001_100_001)
        else $error("Rail drives not at reset decode");

    // Read port: reserved bits, unmapped places and holding between reads
    reserved_zero_a: assert property (regRead |=> regRdData[7:6] == 2'b00)
        else $error("Reserved bits read non-zero");

    unmapped_read_a: assert property (regRead && hit == 3'b000
        |=> regRdData == 8'h00)
        else $error("Unmapped address read non-zero");

    read_hold_a: assert property (!regRead |=> $stable(regRdData))
        else $error("Read data moved without a read");

    read_back_a: assert property (regRead && hit[1] && !regWrite && !exitEdge
        |=> regRdData == {2'b00, $past(ctrl[1])})
        else $error("Read data differs from register");

    // Write, one idle cycle as the host leaves it, then the read of the same place
    write_then_read_a: assert property (regWrite && hit[2] && !exitEdge ##1
        !regWrite && !exitEdge ##1 regRead && hit[2] && !regWrite && !exitEdge
        |=> regRdData == ($past(regWrData, 3) & 8'h3F))
        else $error("Written value not read back");

    // Edge detector held against the pin itself, not against its own flop
    single_copy_a: assert property (standbyExit && $past(standbyExit)
        |-> !exitEdge)
        else $error("Exit copy fired twice");

    // Faults are plain levels one cycle late, never latched
    fault_follow_a: assert property (##1 railFault == $past(railSense))
        else $error("Fault output does not follow monitor");

    generate
        // Per-rail copy, isolation and drive decode
        for (i = 0; i < `RAIL_COUNT; i = i + 1) begin : g_chk
            exit_copy_a: assert property (exitEdge && ctrl[i].exitState[2]
                |=> ctrl[i].state == $past(ctrl[i].exitState))
                else $error("Exit state not copied");

            no_copy_a: assert property (exitEdge && !ctrl[i].exitState[2] && !wrHit[i]
                |=> $stable(ctrl[i].state))
                else $error("State changed on no-copy exit");

            isolation_a: assert property (!wrHit[i] && !exitEdge
                |=> $stable(ctrl[i]))
                else $error("Rail changed without its own write");

            drive_decode_a: assert property (railDrive[i].enable ==
                (ctrl[i].state[2] && ctrl[i].state != 3'h4) &&
                railDrive[i].lowPower == (ctrl[i].state == 3'h5))
                else $error("Drive does not match state");

            discharge_off_a: assert property (
                (!ctrl[i].state[2] || ctrl[i].state == 3'h4)
                |-> railDrive[i].discharge && !railDrive[i].enable)
                else $error("Shut rail not discharged");
        end
    endgenerate

    // -----------------------------------------------------------------
    // Cover points
    // -----------------------------------------------------------------
    // Main scenarios: copy, write, copy racing a write, miss, held pin
    copy_seen_c: cover property (exitEdge && ctrl[2].exitState[2]);
    write_seen_c: cover property (regWrite && hit[0]);
    copy_write_c: cover property (exitEdge && wrHit[1]);
    read_miss_c: cover property (regRead && hit == 3'b000);
    pin_held_c: cover property (standbyExit && $past(standbyExit) && wrHit[0]);

endmodule : ldo_state_control_regs
`default_nettype wire

/* File: pkg/ldo_rail_defines.svh */
// Offsets, reset values, field positions and state codes of the rail control registers.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LDO_RAIL_DEFINES_SVH
`define LDO_RAIL_DEFINES_SVH

// -----------------------------------------------------------------
// Register map (rail index 0 radio, 1 processor always-on, 2 memory)
// -----------------------------------------------------------------
`define RAIL_COUNT          3
`define RADIO_RAIL_ADDR     8'h4C
`define PROC_AON_RAIL_ADDR  8'h3D
`define MEM_RAIL_ADDR       8'h3E
`define RADIO_RAIL_RESET    8'h24
`define PROC_AON_RAIL_RESET 8'h07
`define MEM_RAIL_RESET      8'h3C

// -----------------------------------------------------------------
// Field positions and codes
// -----------------------------------------------------------------
`define STATE_LSB           0
`define STATE_MSB           2
`define EXIT_LSB            3
`define EXIT_MSB            5
`define RESERVED_MSB        7
`define RESERVED_LSB        6
`define CODE_OFF            3'h4
`define CODE_LOW_POWER      3'h5
`define CODE_ACTIVE_A       3'h6
`define CODE_ACTIVE_B       3'h7
`define CODE_VALID_BIT      2
`define EXIT_PIN_RESET      1'b1

`endif

/* File: pkg/ldo_rail_pkg.sv */
// Types shared by the rail control register bank.
// Assumes the defines header sits beside it on the include path.
`include "ldo_rail_defines.svh"

package ldo_rail_pkg;
    // Stored part of one rail register; the two reserved bits are not kept
    typedef struct packed {
        logic [2:0] exitState;   // Loaded into state on standby exit
        logic [2:0] state;       // Present operating state
    } rail_ctrl_t;

    // Drive toward one regulator's analog core
    typedef struct packed {
        logic enable;            // Pass device on
        logic lowPower;          // Low-power regulation
        logic discharge;         // Active output pull-down
    } rail_drive_t;

    // Monitor comparators of one regulator
    typedef struct packed {
        logic overCurrent;
        logic underVoltage;
    } rail_sense_t;
endpackage : ldo_rail_pkg

/* File: bench/host_model.sv */
// Host side of the register port: single-byte writes and reads.
// Assumes strobes are sampled on rising edges of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic       sys_clk,   // Register clock
    output logic [7:0]      regAddr,   // Register address
    output logic            regWrite,  // Write strobe
    output logic [7:0]      regWrData, // Write data
    output logic            regRead,   // Read strobe
    input  wire logic [7:0] regRdData  // Read data
);
    // Idle port at time zero
    initial begin
        regAddr   = 8'h00;
        regWrite  = 1'b0;
        regWrData = 8'h00;
        regRead   = 1'b0;
    end

    // Launch at a falling edge, hold across one rising edge, drop at the next
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        regAddr   = addr;
        regWrData = data;
        regWrite  = 1'b1;
        @(negedge sys_clk);
        regWrite  = 1'b0;
        regWrData = ~data; // Stale data must not pass for fresh
    endtask : wr

    // Read data lands at the edge that takes the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge sys_clk);
        regAddr = addr;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        data    = regRdData;
    endtask : rd

    // Power-up set-up of all three rails, exit fields included
    task automatic initExit(input logic [7:0] radio, proc, mem);
        wr(8'h4C, radio);
        wr(8'h3D, proc);
        wr(8'h3E, mem);
    endtask : initExit
endmodule : host_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the rail state control registers.
// Assumes the host model drives the register port; the bench drives the pins.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ldo_rail_pkg::*;
    logic              sys_clk, rst, regWrite, regRead, standbyExit;
    logic [7:0]        regAddr, regWrData, regRdData, rdVal;
    rail_sense_t [2:0] railSense;
    rail_drive_t [2:0] railDrive;
    rail_sense_t [2:0] railFault;
    int                failures = 0;
    int                checksDone = 0;
    int                cycles = 0;

    ldo_state_control_regs dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
        .regRdData(regRdData), .standbyExit(standbyExit), .railSense(railSense),
        .railDrive(railDrive), .railFault(railFault));
    host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData));

    // ------------------------------------------------------------
    // Clock, watchdog and checking helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Whole sequence needs about 70 cycles; a hang ends the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    task automatic compare(input string what, input logic [8:0] exp, got);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic rdChk(input logic [7:0] addr, exp);
        host.rd(addr, rdVal);
        compare("regRdData", {1'b0, exp}, {1'b0, rdVal});
    endtask : rdChk

    // Reserved codes count as off, so the output is discharged then
    function automatic logic [2:0] driveOf(input logic [2:0] code);
        if (code == 3'h5) return 3'b110;
        if (code[2] && code[1]) return 3'b100;
        return 3'b001;
    endfunction : driveOf

    task automatic results;
        if (failures == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst         = 1'b1;
        standbyExit = 1'b0;
        railSense   = 6'h00;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        rdChk(8'h4C, 8'h24);
        rdChk(8'h3D, 8'h07);
        rdChk(8'h3E, 8'h3C);
        compare("railDrive", 9'b001_100_001, railDrive);
        // Unmapped place ignores writes and reads zero
        host.wr(8'h40, 8'h3F);
        rdChk(8'h40, 8'h00);
        host.wr(8'h3D, 8'hFF);
        rdChk(8'h3D, 8'h3F);
        rdChk(8'h4C, 8'h24);
        rdChk(8'h3E, 8'h3C);
        host.wr(8'h3E, 8'hE5);
        rdChk(8'h3E, 8'h25);
        // Every state code on the radio rail, reserved ones included
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h4C, 8'(c));
            compare("radioDrive", {6'h00, driveOf(3'(c))}, {6'h00, railDrive[0]});
        end
        // Exit copy: radio to low power, processor no copy, memory to active
        host.initExit(8'h2C, 8'h16, 8'h3C);
        standbyExit = 1'b1;
        repeat (4) @(negedge sys_clk);
        rdChk(8'h4C, 8'h2D);
        rdChk(8'h3D, 8'h16);
        rdChk(8'h3E, 8'h3F);
        // Pin still high: a new write must survive
        host.wr(8'h4C, 8'h2C);
        repeat (3) @(negedge sys_clk);
        rdChk(8'h4C, 8'h2C);
        standbyExit = 1'b0;
        @(negedge sys_clk);
        standbyExit = 1'b1;
        @(negedge sys_clk);
        compare("railDrive", 9'b100_100_110, railDrive);
        standbyExit = 1'b0;
        // Monitor levels reach the fault outputs one cycle late
        for (int k = 0; k < 3; k++) begin
            railSense = (k == 0) ? 6'h3F : (k == 1) ? 6'h15 : 6'h2A;
            @(negedge sys_clk);
            compare("railFault", {3'b000, railSense}, {3'b000, railFault});
        end
        results();
    end
endmodule : testbench
`default_nettype wire
